/* File: spi_switch_regs.sv */
// Register bank of the quad switch: frame receiver, checks and registers.
// Assumes link pins are asynchronous to mclk_i and sclk half periods span several mclk_i cycles.
//
// The implementer's own choice: the strobed register port.
`default_nettype none
module spi_switch_regs (
  input  wire logic       mclk_i,          // System clock
  input  wire logic       rst_b_i,         // Async reset, active low
  spi_link_if.device      link,            // Serial link
  output logic [3:0]      switch_close_o,  // Switch four..one closed
  output logic [2:0]      error_flags_o    // Address, clock count, CRC flags
);
  typedef struct packed {
    logic        cs_m;
    logic        cs_s;
    logic        cs_d;
    logic        sck_m;
    logic        sck_s;
    logic        sck_d;
    logic        sdi_m;
    logic        sdi_s;
    logic [23:0] shift;
    logic [4:0]  bitpos;
    logic [1:0]  ncmd;
    logic        pend;
    logic [23:0] held;
    logic [7:0]  out;
    logic        sdo;
    logic [3:0]  sw;
    logic [2:0]  en;
    logic [2:0]  flags;
    logic        burst;
    logic [7:0]  key;
    logic        armed;
  } dev_state_type;

  dev_state_type s;
  dev_state_type next_s;

  function automatic logic addr_ok(input logic [6:0] a, input logic rd);
    logic ok;
    ok = 1'b0;
    unique case (a)
      spi_switch_pkg::ADDR_SWITCH_STATE,
      spi_switch_pkg::ADDR_ERROR_ENABLES,
      spi_switch_pkg::ADDR_BURST,
      spi_switch_pkg::ADDR_SOFT_RESET:  ok = 1'b1;
      spi_switch_pkg::ADDR_ERROR_FLAGS: ok = rd;
      default:                          ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic [7:0] reg_read(input dev_state_type st, input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      spi_switch_pkg::ADDR_SWITCH_STATE:  v = {4'h0, st.sw};
      spi_switch_pkg::ADDR_ERROR_ENABLES: v = {5'h00, st.en};
      spi_switch_pkg::ADDR_ERROR_FLAGS:   v = {5'h00, st.flags};
      spi_switch_pkg::ADDR_BURST:         v = {7'h00, st.burst};
      spi_switch_pkg::ADDR_SOFT_RESET:    v = st.key;
      default:                            v = 8'h00;
    endcase
    return v;
  endfunction

  function automatic dev_state_type soft_reset(input dev_state_type st);
    dev_state_type r;
    r = st;
    r.sw    = spi_switch_pkg::RST_SWITCH_STATE[3:0];
    r.en    = spi_switch_pkg::RST_ERROR_ENABLES[2:0];
    r.flags = spi_switch_pkg::RST_ERROR_FLAGS[2:0];
    r.burst = spi_switch_pkg::RST_BURST[0];
    r.key   = spi_switch_pkg::RST_SOFT_RESET;
    r.armed = 1'b0;
    return r;
  endfunction

  // Applies one received command to the register state
  function automatic dev_state_type commit(input dev_state_type st, input logic [15:0] cmd,
                                           input logic [7:0] chk);
    dev_state_type r;
    logic [6:0]    a;
    logic [7:0]    d;
    logic          rd;
    logic          was_armed;
    r         = st;
    a         = cmd[14:8];
    d         = cmd[7:0];
    rd        = cmd[spi_switch_pkg::CMD_READ_BIT];
    was_armed = st.armed;
    r.armed   = 1'b0;
    if (st.en[spi_switch_pkg::EN_CRC_BIT] && chk != spi_switch_pkg::crc8(cmd))
    begin
      r.flags[spi_switch_pkg::FLAG_CRC_BIT] = 1'b1;
    end
    else if (cmd == spi_switch_pkg::CMD_CLEAR_FLAGS)
    begin
      r.flags = 3'h0;
    end
    else if (!addr_ok(a, rd))
    begin
      if (st.en[spi_switch_pkg::EN_RW_BIT])
      begin
        r.flags[spi_switch_pkg::FLAG_RW_BIT] = 1'b1;
      end
    end
    else if (!rd)
    begin
      unique case (a)
        spi_switch_pkg::ADDR_SWITCH_STATE:  r.sw = d[3:0];
        spi_switch_pkg::ADDR_ERROR_ENABLES: r.en = d[2:0];
        spi_switch_pkg::ADDR_BURST:         r.burst = d[spi_switch_pkg::BURST_BIT];
        spi_switch_pkg::ADDR_SOFT_RESET:
        begin
          if (was_armed && d == spi_switch_pkg::KEY_SECOND)
          begin
            r = soft_reset(st);
          end
          else
          begin
            r.key   = d;
            r.armed = (d == spi_switch_pkg::KEY_FIRST);
          end
        end
        default: r = r;
      endcase
    end
    return r;
  endfunction

  always_comb
  begin
    logic [4:0] len;
    logic       rise;
    logic       fall;
    logic       active;
    logic       cs_rise;
    logic       bad;
    next_s       = s;
    len          = 5'h00;
    rise         = 1'b0;
    fall         = 1'b0;
    active       = 1'b0;
    cs_rise      = 1'b0;
    bad          = 1'b0;
    next_s.cs_m  = link.cs_b;
    next_s.cs_s  = s.cs_m;
    next_s.cs_d  = s.cs_s;
    next_s.sck_m = link.sclk;
    next_s.sck_s = s.sck_m;
    next_s.sck_d = s.sck_s;
    next_s.sdi_m = link.sdi;
    next_s.sdi_s = s.sdi_m;
    len     = s.en[spi_switch_pkg::EN_CRC_BIT] ? spi_switch_pkg::BITS_CRC : spi_switch_pkg::BITS_PLAIN;
    rise    = s.sck_s & ~s.sck_d;
    fall    = ~s.sck_s & s.sck_d;
    active  = ~s.cs_s;
    cs_rise = s.cs_s & ~s.cs_d;
    if (active && rise)
    begin
      next_s.shift = {s.shift[22:0], s.sdi_s};
      if (s.bitpos == len - 5'h01)
      begin
        next_s.bitpos = 5'h00;
        next_s.ncmd   = (s.ncmd == 2'h2) ? 2'h2 : s.ncmd + 2'h1;
        if (s.burst)
        begin
          next_s = commit(next_s, s.en[spi_switch_pkg::EN_CRC_BIT] ? next_s.shift[23:8] : next_s.shift[15:0],
                          next_s.shift[7:0]);
        end
        else if (s.ncmd == 2'h0)
        begin
          next_s.pend = 1'b1;
          next_s.held = next_s.shift;
        end
      end
      else
      begin
        next_s.bitpos = s.bitpos + 5'h01;
      end
      if (s.bitpos == spi_switch_pkg::BITS_BYTE)
      begin
        next_s.out = next_s.shift[7] ? reg_read(s, next_s.shift[6:0]) : 8'h00;
      end
    end
    if (active && fall)
    begin
      next_s.sdo = s.out[7];
      next_s.out = {s.out[6:0], 1'b0};
    end
    if (cs_rise)
    begin
      if (s.burst)
      begin
        bad = (s.bitpos != 5'h00);
      end
      else
      begin
        bad = !(s.ncmd == 2'h1 && s.bitpos == 5'h00);
      end
      if (bad && s.en[spi_switch_pkg::EN_SCLK_BIT])
      begin
        next_s.flags[spi_switch_pkg::FLAG_SCLK_BIT] = 1'b1;
      end
      else if (!s.burst && s.pend)
      begin
        next_s = commit(next_s, s.en[spi_switch_pkg::EN_CRC_BIT] ? s.held[23:8] : s.held[15:0], s.held[7:0]);
      end
      next_s.bitpos = 5'h00;
      next_s.ncmd   = 2'h0;
      next_s.pend   = 1'b0;
      next_s.out    = 8'h00;
      next_s.sdo    = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s <= '{cs_m: 1'b1, cs_s: 1'b1, cs_d: 1'b1,
             sw: spi_switch_pkg::RST_SWITCH_STATE[3:0],
             en: spi_switch_pkg::RST_ERROR_ENABLES[2:0],
             flags: spi_switch_pkg::RST_ERROR_FLAGS[2:0],
             burst: spi_switch_pkg::RST_BURST[0],
             key: spi_switch_pkg::RST_SOFT_RESET,
             default: '0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign link.sdo       = s.sdo;
  assign switch_close_o = s.sw;
  assign error_flags_o  = s.flags;
endmodule
`default_nettype wire

/* File: spi_switch_pkg.sv */
// Shared constants of the SPI-controlled quad switch register bank and its host.
// Assumes a single 100 MHz system clock on both ends of the link.
`default_nettype none
package spi_switch_pkg;
  // Register addresses
  localparam logic [6:0] ADDR_SWITCH_STATE  = 7'h01;
  localparam logic [6:0] ADDR_ERROR_ENABLES = 7'h02;
  localparam logic [6:0] ADDR_ERROR_FLAGS   = 7'h03;
  localparam logic [6:0] ADDR_BURST         = 7'h05;
  localparam logic [6:0] ADDR_SOFT_RESET    = 7'h0B;
  // Values after reset
  localparam logic [7:0] RST_SWITCH_STATE  = 8'h00;
  localparam logic [7:0] RST_ERROR_ENABLES = 8'h06;
  localparam logic [7:0] RST_ERROR_FLAGS   = 8'h00;
  localparam logic [7:0] RST_BURST         = 8'h00;
  localparam logic [7:0] RST_SOFT_RESET    = 8'h00;
  // Field positions
  localparam int SWITCH_BITS   = 4;
  localparam int EN_RW_BIT     = 2;
  localparam int EN_SCLK_BIT   = 1;
  localparam int EN_CRC_BIT    = 0;
  localparam int FLAG_RW_BIT   = 2;
  localparam int FLAG_SCLK_BIT = 1;
  localparam int FLAG_CRC_BIT  = 0;
  localparam int BURST_BIT     = 0;
  localparam int CMD_READ_BIT  = 15;
  // Commands and keys
  localparam logic [15:0] CMD_CLEAR_FLAGS = 16'h6CA9;
  localparam logic [7:0]  KEY_FIRST       = 8'hA3;
  localparam logic [7:0]  KEY_SECOND      = 8'h05;
  // Frame lengths in serial clock cycles, last bit index of the first byte, CRC polynomial and start value
  localparam logic [4:0] BITS_PLAIN = 5'h10;
  localparam logic [4:0] BITS_CRC   = 5'h18;
  localparam logic [4:0] BITS_BYTE  = 5'h07;
  localparam logic [7:0] CRC_POLY   = 8'h07;
  localparam logic [7:0] CRC_INIT   = 8'h00;
  // Host register map and timing
  localparam logic [1:0] HOST_ADDR_COMMAND = 2'h0;
  localparam logic [1:0] HOST_ADDR_CONTROL = 2'h1;
  localparam logic [1:0] HOST_ADDR_STATUS  = 2'h2;
  localparam int CTRL_CRC_BIT  = 0;
  localparam int CTRL_HOLD_BIT = 1;
  localparam logic [1:0] RST_HOST_CONTROL = 2'h0;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS  = 80;
  localparam logic [3:0] SCLK_HALF_CYCLES = 4'(SCLK_HALF_NS / CLK_PERIOD_NS);

  // Check byte over a 16-bit command, MSB first
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--)
    begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction
endpackage
`default_nettype wire

/* File: spi_link_if.sv */
// Four-wire serial link between the switch register bank and its host.
// Assumes both ends are clocked by their own system clock; sclk is a plain signal.
`default_nettype none
interface spi_link_if;
  logic cs_b;
  logic sclk;
  logic sdi;
  logic sdo;
  modport device (input cs_b, input sclk, input sdi, output sdo);
  modport host   (output cs_b, output sclk, output sdi, input sdo);
endinterface
`default_nettype wire

/* File: spi_switch_host.sv */
// Host end of the link: sends one command frame per software request.
// Assumes the register bank samples the link with a short synchroniser delay.
`default_nettype none
module spi_switch_host (
  input  wire logic        mclk_i,   // System clock
  input  wire logic        rst_b_i,  // Async reset, active low
  spi_link_if.host         link,     // Serial link
  input  wire logic [1:0]  addr_i,   // Register address
  input  wire logic [15:0] wdata_i,  // Write data
  input  wire logic        wr_i,     // Write strobe
  input  wire logic        rd_i,     // Read strobe
  output logic [15:0]      rdata_o   // Read data, cycle after rd_i
);
  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} host_phase_type;

  typedef struct packed {
    host_phase_type phase;
    logic           cs_b;
    logic           sclk;
    logic [23:0]    tx;
    logic [15:0]    rx;
    logic [7:0]     rbyte;
    logic           sdo_m;
    logic           sdo_s;
    logic [3:0]     div;
    logic [4:0]     nbits;
    logic [1:0]     ctrl;
    logic [15:0]    rdata;
  } host_state_type;

  host_state_type s;
  host_state_type next_s;

  always_comb
  begin
    logic [4:0] len;
    next_s       = s;
    next_s.sdo_m = link.sdo;
    next_s.sdo_s = s.sdo_m;
    next_s.rdata = 16'h0000;
    len = s.ctrl[spi_switch_pkg::CTRL_CRC_BIT] ? spi_switch_pkg::BITS_CRC : spi_switch_pkg::BITS_PLAIN;
    if (rd_i)
    begin
      if (addr_i == spi_switch_pkg::HOST_ADDR_STATUS)
      begin
        // Busy also covers the cycle in which a finished frame is still closing cs_b
        next_s.rdata = {s.rbyte, 6'h00, ~s.cs_b,
                        (s.phase != H_IDLE) || (!s.cs_b && !s.ctrl[spi_switch_pkg::CTRL_HOLD_BIT])};
      end
      else if (addr_i == spi_switch_pkg::HOST_ADDR_CONTROL)
      begin
        next_s.rdata = {14'h0000, s.ctrl};
      end
    end
    if (wr_i && addr_i == spi_switch_pkg::HOST_ADDR_CONTROL)
    begin
      next_s.ctrl = wdata_i[1:0];
    end
    unique case (s.phase)
      H_IDLE:
      begin
        // Closing a frame comes first, so with the hold bit clear a new command never runs on without a cs_b rise
        if (!s.cs_b && !s.ctrl[spi_switch_pkg::CTRL_HOLD_BIT])
        begin
          next_s.cs_b  = 1'b1;
          next_s.div   = 4'h0;
          next_s.phase = H_GAP;
        end
        else if (wr_i && addr_i == spi_switch_pkg::HOST_ADDR_COMMAND)
        begin
          next_s.tx    = {wdata_i, spi_switch_pkg::crc8(wdata_i)};
          next_s.cs_b  = 1'b0;
          next_s.sclk  = 1'b0;
          next_s.div   = 4'h0;
          next_s.nbits = 5'h00;
          next_s.phase = H_SHIFT;
        end
      end
      H_SHIFT:
      begin
        if (s.div == spi_switch_pkg::SCLK_HALF_CYCLES - 4'h1)
        begin
          next_s.div  = 4'h0;
          next_s.sclk = ~s.sclk;
          if (!s.sclk)
          begin
            next_s.rx    = {s.rx[14:0], s.sdo_s};
            next_s.nbits = s.nbits + 5'h01;
          end
          else
          begin
            next_s.tx = {s.tx[22:0], 1'b0};
            if (s.nbits == len)
            begin
              next_s.rbyte = (len == spi_switch_pkg::BITS_CRC) ? s.rx[15:8] : s.rx[7:0];
              next_s.phase = H_IDLE;
            end
          end
        end
        else
        begin
          next_s.div = s.div + 4'h1;
        end
      end
      H_GAP:
      begin
        if (s.div == spi_switch_pkg::SCLK_HALF_CYCLES - 4'h1)
        begin
          next_s.phase = H_IDLE;
        end
        else
        begin
          next_s.div = s.div + 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s <= '{phase: H_IDLE, cs_b: 1'b1, ctrl: spi_switch_pkg::RST_HOST_CONTROL, default: '0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign link.cs_b = s.cs_b;
  assign link.sclk = s.sclk;
  assign link.sdi  = s.tx[23];
  assign rdata_o   = s.rdata;
endmodule
`default_nettype wire

/* File: spi_switch_chk.sv */
// Checker of the serial link between the switch register bank and its host.
// Assumes the host timing: sclk half period of 8 mclk_i cycles, frames framed by cs_b.
`default_nettype none
module spi_switch_chk (
  input wire logic       mclk_i,          // System clock
  input wire logic       rst_b_i,         // Async reset, active low
  input wire logic       cs_b,            // Frame select
  input wire logic       sclk,            // Serial clock
  input wire logic       sdi,             // Host to device data
  input wire logic       sdo,             // Device to host data
  input wire logic [3:0] switch_close_o,  // Switch closed bits
  input wire logic [2:0] error_flags_o    // Error flags
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        sclk_q;
  logic        cs_q;
  logic [15:0] rises;
  logic [7:0]  since;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  // Rising sclk edges in the current frame, and age of the last link event
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
      rises  <= 16'h0000;
      since  <= 8'hFF;
    end
    else
    begin
      sclk_q <= sclk;
      cs_q   <= cs_b;
      rises  <= cs_b ? 16'h0000 : rises + 16'(sclk && !sclk_q);
      since  <= ((sclk && !sclk_q) || (cs_b && !cs_q)) ? 8'h00 : ((since == 8'hFF) ? since : since + 8'h01);
    end
  end

  a_idle_clock_low: assert property (cs_b |-> !sclk)
    else $error("sclk high outside a frame");
  a_clock_high_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("sclk high phase not 8 cycles");
  a_clock_low_half: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("sclk low phase shorter than 8 cycles");
  a_frame_lead: assert property ($fell(cs_b) |-> !sclk [*8])
    else $error("sclk rose too soon after frame start");
  a_data_steady: assert property ($rose(sclk) |-> $stable(sdi) [*8])
    else $error("sdi moved while sclk high");
  a_frame_length: assert property ($rose(cs_b) |-> rises != 0 && (rises % 16 == 0 || rises % 24 == 0))
    else $error("frame clock count not a whole command");
  a_switch_commit: assert property ($changed(switch_close_o) |-> since <= 8'h0C)
    else $error("switch state changed away from a frame end");
  a_flags_commit: assert property ($changed(error_flags_o) |-> since <= 8'h0C)
    else $error("error flags changed away from a frame end");

  c_crc_frame: cover property ($rose(cs_b) && rises == 16'h0018);
  c_burst_frame: cover property ($rose(cs_b) && rises == 16'h0050);
  c_addr_flag: cover property ($rose(error_flags_o[2]));
  c_read_data: cover property (!cs_b && sdo);
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench: host and register bank joined by the link, driven at the host port.
// Assumes status reads as {response byte, 6'b0, cs low, busy}.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [15:0] word; logic [7:0] rsp; logic [3:0] sw; logic [2:0] flags;} row_type;
  logic        mclk_i  = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [1:0]  addr_i  = 2'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic [15:0] rdata_o;
  logic [3:0]  switch_close_o;
  logic [2:0]  error_flags_o;
  logic [15:0] st;
  int          error_cnt = 0;
  int          tests_run = 0;
  row_type     rows [13];
  spi_link_if link ();
  spi_switch_host i_spi_switch_host (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .link(link.host), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
  spi_switch_regs i_spi_switch_regs (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .link(link.device),
    .switch_close_o(switch_close_o), .error_flags_o(error_flags_o));
  spi_switch_chk i_spi_switch_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .cs_b(link.cs_b), .sclk(link.sclk),
    .sdi(link.sdi), .sdo(link.sdo), .switch_close_o(switch_close_o), .error_flags_o(error_flags_o));

  always #5 mclk_i = ~mclk_i;

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_outs(input logic [3:0] sw, input logic [2:0] flags);
    check("switch_close_o", {12'h000, sw}, {12'h000, switch_close_o});
    check("error_flags_o", {13'h0000, flags}, {13'h0000, error_flags_o});
  endtask

  task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic bus_rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  // Poll busy; the last status keeps the response byte
  task automatic wait_idle();
    int n;
    n = 0;
    st = 16'h0001;
    while (st[0] !== 1'b0 && n < 1000)
    begin
      bus_rd(spi_switch_pkg::HOST_ADDR_STATUS, st);
      n++;
    end
    if (n == 1000) check("busy", 16'h0000, st);
  endtask

  // One command, then wait until the host is idle again
  task automatic send(input logic [15:0] word);
    bus_wr(spi_switch_pkg::HOST_ADDR_COMMAND, word);
    wait_idle();
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge mclk_i);
    error_cnt++;
    summarize();
  end

  initial
  begin
    rows = '{'{16'h010F, 8'h00, 4'hF, 3'h0}, '{16'h010A, 8'h00, 4'hA, 3'h0}, '{16'h8100, 8'h0A, 4'hA, 3'h0},
             '{16'h8200, 8'h06, 4'hA, 3'h0}, '{16'h8300, 8'h00, 4'hA, 3'h0}, '{16'h8500, 8'h00, 4'hA, 3'h0},
             '{16'h8B00, 8'h00, 4'hA, 3'h0}, '{16'h0400, 8'h00, 4'hA, 3'h4}, '{16'h6CA9, 8'h00, 4'hA, 3'h0},
             '{16'h0312, 8'h00, 4'hA, 3'h4}, '{16'h6CA9, 8'h00, 4'hA, 3'h0}, '{16'h8700, 8'h00, 4'hA, 3'h4},
             '{16'h6CA9, 8'h00, 4'hA, 3'h0}};
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    foreach (rows[i])
    begin
      send(rows[i].word);
      check_outs(rows[i].sw, rows[i].flags);
      if (rows[i].word[15]) check("response", {8'h00, rows[i].rsp}, {8'h00, st[15:8]});
    end
    send(16'h0202);
    send(16'h0400);
    check_outs(4'hA, 3'h0);
    send(16'h0204);
    bus_wr(spi_switch_pkg::HOST_ADDR_CONTROL, 16'h0001);
    bus_rd(spi_switch_pkg::HOST_ADDR_CONTROL, st);
    check("control", 16'h0001, st);
    send(16'h0105);
    check_outs(4'h5, 3'h0);
    send(16'h0206);
    send(16'h010C);
    check_outs(4'h5, 3'h2);
    bus_wr(spi_switch_pkg::HOST_ADDR_CONTROL, 16'h0000);
    send(16'h6CA9);
    check_outs(4'h5, 3'h0);
    send(16'h0207);
    bus_wr(spi_switch_pkg::HOST_ADDR_CONTROL, 16'h0001);
    send(16'h0103);
    check_outs(4'h3, 3'h0);
    bus_wr(spi_switch_pkg::HOST_ADDR_CONTROL, 16'h0000);
    send(16'h0109);
    check_outs(4'h3, 3'h2);
    bus_wr(spi_switch_pkg::HOST_ADDR_CONTROL, 16'h0001);
    send(16'h6CA9);
    check_outs(4'h3, 3'h0);
    send(16'h0206);
    bus_wr(spi_switch_pkg::HOST_ADDR_CONTROL, 16'h0000);
    // Burst: two commands under one cs_b low period
    send(16'h0501);
    bus_wr(spi_switch_pkg::HOST_ADDR_CONTROL, 16'h0002);
    send(16'h0106);
    check_outs(4'h6, 3'h0);
    check("cs_b", 16'h0000, {15'h0000, link.cs_b});
    check("status", 16'h0002, {14'h0000, st[1:0]});
    send(16'h0109);
    check_outs(4'h9, 3'h0);
    // Device CRC on, host still 16-bit: one command straddles frames with a wrong check byte
    send(16'h0207);
    send(16'h0103);
    send(16'h0000);
    bus_wr(spi_switch_pkg::HOST_ADDR_CONTROL, 16'h0000);
    wait_idle();
    check_outs(4'h9, 3'h3);
    bus_wr(spi_switch_pkg::HOST_ADDR_CONTROL, 16'h0001);
    send(16'h6CA9);
    check_outs(4'h9, 3'h0);
    send(16'h0206);
    bus_wr(spi_switch_pkg::HOST_ADDR_CONTROL, 16'h0000);
    send(16'h0500);
    // Interrupted key sequence, then a complete one
    send(16'h0BA3);
    send(16'h0107);
    send(16'h0B05);
    check_outs(4'h7, 3'h0);
    send(16'h0202);
    send(16'h0BA3);
    send(16'h0B05);
    check_outs(4'h0, 3'h0);
    send(16'h8200);
    check("enables", 16'h0006, {8'h00, st[15:8]});
    // Hardware reset in mid-run
    send(16'h010F);
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    #1 check_outs(4'h0, 3'h0);
    send(16'h8200);
    check("enables", 16'h0006, {8'h00, st[15:8]});
    summarize();
  end
endmodule
`default_nettype wire
